// [rtl/axis_homing_sequencer.sv]
// module: homing sequencer for one motion axis, modes 1 to 9
`timescale 1ns/1ps

module axis_homing_sequencer (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          homing_command,
  input  wire logic [homing_pkg::MODE_W-1:0] mode,
  input  wire homing_pkg::sw_type            sw_pins,
  output homing_pkg::motion_type             motion_r,
  output logic                               busy_r,
  output logic                               homing_done_r,
  output logic                               command_refused_r
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // a mode this sequencer knows how to run
  function automatic logic mode_ok(input logic [homing_pkg::MODE_W-1:0] m);
    mode_ok = (m >= homing_pkg::MODE_NEG_LIMIT) && (m <= homing_pkg::MODE_HOME_PL_PAS);
  endfunction : mode_ok

  // the switch that decides the start branch and the first trigger
  function automatic logic act_sw(input logic [homing_pkg::MODE_W-1:0] m,
                                  input homing_pkg::sw_type s);
    if (m == homing_pkg::MODE_NEG_LIMIT) begin
      act_sw = s.neg_limit;
    end else if (m == homing_pkg::MODE_POS_LIMIT) begin
      act_sw = s.pos_limit;
    end else begin
      act_sw = s.home_sw;
    end
  endfunction : act_sw

  // first move: second-phase speed when the switch is already active
  function automatic homing_pkg::motion_type first_move(
      input logic [homing_pkg::MODE_W-1:0] m, input logic on);
    homing_pkg::motion_type mv;
    mv.move   = 1'b1;
    mv.phase2 = on;
    case (m)
      homing_pkg::MODE_NEG_LIMIT: mv.dir_pos = on;
      homing_pkg::MODE_POS_LIMIT: mv.dir_pos = ~on;
      homing_pkg::MODE_HOME_NREV,
      homing_pkg::MODE_HOME_NFWD: mv.dir_pos = on;
      homing_pkg::MODE_HOME_PL_PAS: mv.dir_pos = 1'b1;
      default: mv.dir_pos = ~on;
    endcase
    first_move = mv;
  endfunction : first_move

  // build a moving command
  function automatic homing_pkg::motion_type go(input logic dir_pos, input logic phase2);
    homing_pkg::motion_type mv;
    mv.move    = 1'b1;
    mv.dir_pos = dir_pos;
    mv.phase2  = phase2;
    go = mv;
  endfunction : go

  // the six codes the sequencer walks; any other code is treated as a fault
  function automatic logic state_known(input homing_pkg::state_type s);
    case (s)
      homing_pkg::ST_IDLE,
      homing_pkg::ST_LEG1,
      homing_pkg::ST_LEG2,
      homing_pkg::ST_LEG3,
      homing_pkg::ST_LEG4,
      homing_pkg::ST_INDEX: state_known = 1'b1;
      default:              state_known = 1'b0;
    endcase
  endfunction : state_known

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // switches and the index arrive from the machine with no relation to clk

  homing_pkg::sw_type    sync1_r;
  homing_pkg::sw_type    sw_r;
  homing_pkg::sw_type    sw_prev_r;
  logic                  z_rise;

  // two flops per pin; sync1_r is read by sw_r alone
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r   <= homing_pkg::SW_RESET;
      sw_r      <= homing_pkg::SW_RESET;
      sw_prev_r <= homing_pkg::SW_RESET;
    end else begin
      sync1_r   <= sw_pins;
      sw_r      <= sync1_r;
      sw_prev_r <= sw_r;
    end
  end

  // index edge detector works on the settled copy
  assign z_rise = sw_r.index_z & ~sw_prev_r.index_z;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  //
  // limitation: there is no abort; only reset ends a run before its index edge
  // trade-off: switch levels act 3 cycles after the pin moves, so the axis
  // overshoots each trigger by that much travel before the new command

  homing_pkg::state_type           state_r;
  logic [homing_pkg::MODE_W-1:0]   mode_r;
  logic                            on_r;      // switch active at command
  logic                            lim_r;     // mode 8 must still cross the switch
  logic                            idx_hs_r;  // index only counts while switch is on
  logic                            trig;

  // trigger switch level for the latched mode
  assign trig = act_sw(mode_r, sw_r);

  // strobes shared by the sequencer and the status flags
  logic                            idle_cmd;  // command seen while idle
  logic                            start_ok;  // command with a mode this block runs
  logic                            home_hit;  // qualifying index edge, the run ends here

  // commands only count in idle; a held command restarts once done has gone out
  assign idle_cmd = (state_r == homing_pkg::ST_IDLE) && homing_command;
  assign start_ok = idle_cmd && mode_ok(mode);

  // paths that end on the switch only accept an index edge while it is still on
  assign home_hit = (state_r == homing_pkg::ST_INDEX) && z_rise &&
                    (!idx_hs_r || sw_r.home_sw);

  // one process owns the whole sequence so leg changes and motion stay in step
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r           <= homing_pkg::ST_IDLE;
      mode_r            <= homing_pkg::MODE_NEG_LIMIT;
      on_r              <= 1'b0;
      lim_r             <= 1'b0;
      idx_hs_r          <= 1'b0;
      motion_r          <= homing_pkg::MOTION_RESET;
    end else begin
      case (state_r)
        homing_pkg::ST_IDLE: begin
          if (start_ok) begin
            // branch is latched here and only mode 9 sets it again; other switch changes steer legs only
            mode_r   <= mode;
            on_r     <= act_sw(mode, sw_r);
            lim_r    <= 1'b0;
            idx_hs_r <= 1'b0;
            motion_r <= first_move(mode, act_sw(mode, sw_r));
            state_r  <= homing_pkg::ST_LEG1;
          end
        end

        // first leg: wait for the start switch to change, or in modes 7 to 9 for the positive limit
        homing_pkg::ST_LEG1: begin
          if (on_r) begin
            if (!trig) begin
              case (mode_r)
                homing_pkg::MODE_HOME_FWD,
                homing_pkg::MODE_HOME_PL_FWD: begin
                  motion_r <= go(1'b1, 1'b1);
                end
                homing_pkg::MODE_HOME_NFWD,
                homing_pkg::MODE_HOME_PL_PAS: begin
                  motion_r <= go(1'b0, 1'b1);
                end
                default: begin
                  motion_r <= motion_r;
                end
              endcase
              state_r <= homing_pkg::ST_INDEX;
            end
          end else begin
            case (mode_r)
              homing_pkg::MODE_HOME_FWD: begin
                if (trig) begin
                  motion_r <= go(motion_r.dir_pos, 1'b1);
                  state_r  <= homing_pkg::ST_INDEX;
                end
              end
              homing_pkg::MODE_HOME_NFWD: begin
                if (trig) begin
                  motion_r <= go(motion_r.dir_pos, 1'b1);
                  idx_hs_r <= 1'b1;
                  state_r  <= homing_pkg::ST_INDEX;
                end
              end
              homing_pkg::MODE_HOME_PL_REV: begin
                if (trig) begin
                  motion_r <= go(~motion_r.dir_pos, 1'b1);
                  state_r  <= homing_pkg::ST_LEG2;
                end else if (sw_r.pos_limit) begin
                  motion_r <= go(1'b0, 1'b0);
                  state_r  <= homing_pkg::ST_LEG3;
                end
              end
              homing_pkg::MODE_HOME_PL_FWD: begin
                if (trig) begin
                  motion_r <= go(motion_r.dir_pos, 1'b1);
                  idx_hs_r <= 1'b1;
                  state_r  <= homing_pkg::ST_INDEX;
                end else if (sw_r.pos_limit) begin
                  motion_r <= go(1'b0, 1'b0);
                  lim_r    <= 1'b1;
                  state_r  <= homing_pkg::ST_LEG3;
                end
              end
              homing_pkg::MODE_HOME_PL_PAS: begin
                if (trig) begin
                  // slow down and reuse the on-branch for the reversal
                  motion_r <= go(motion_r.dir_pos, 1'b1);
                  on_r     <= 1'b1;
                end else if (sw_r.pos_limit) begin
                  motion_r <= go(1'b0, 1'b0);
                  state_r  <= homing_pkg::ST_LEG3;
                end
              end
              default: begin
                if (trig) begin
                  motion_r <= go(~motion_r.dir_pos, 1'b1);
                  state_r  <= homing_pkg::ST_LEG2;
                end
              end
            endcase
          end
        end

        // second-phase speed, reversed or in mode 7 still moving negative after the limit: wait for the switch to clear
        homing_pkg::ST_LEG2: begin
          if (!trig) begin
            state_r <= homing_pkg::ST_INDEX;
          end
        end

        // after a positive-limit reversal: wait for the home switch
        homing_pkg::ST_LEG3: begin
          if (sw_r.home_sw) begin
            case (mode_r)
              homing_pkg::MODE_HOME_PL_REV: begin
                motion_r <= go(motion_r.dir_pos, 1'b1);
                state_r  <= homing_pkg::ST_LEG2;
              end
              homing_pkg::MODE_HOME_PL_FWD: begin
                if (lim_r) begin
                  state_r <= homing_pkg::ST_LEG4;
                end else begin
                  motion_r <= go(motion_r.dir_pos, 1'b1);
                  idx_hs_r <= 1'b1;
                  state_r  <= homing_pkg::ST_INDEX;
                end
              end
              default: begin
                motion_r <= go(motion_r.dir_pos, 1'b1);
                idx_hs_r <= 1'b1;
                state_r  <= homing_pkg::ST_INDEX;
              end
            endcase
          end
        end

        // mode 8 crossing the switch at first-phase speed, reverse on its far side
        homing_pkg::ST_LEG4: begin
          if (!sw_r.home_sw) begin
            motion_r <= go(~motion_r.dir_pos, 1'b0);
            lim_r    <= 1'b0;
            state_r  <= homing_pkg::ST_LEG3;
          end
        end

        // wait for the qualifying index edge
        homing_pkg::ST_INDEX: begin
          if (home_hit) begin
            motion_r <= homing_pkg::MOTION_RESET;
            state_r  <= homing_pkg::ST_IDLE;
          end
        end

        default: begin
          motion_r <= homing_pkg::MOTION_RESET;
          state_r  <= homing_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  // each flag has its own process so a change to one cannot disturb the others

  // busy spans the run and also drops if the sequencer has to fall back to idle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
    end else if (start_ok) begin
      busy_r <= 1'b1;
    end else if (home_hit || !state_known(state_r)) begin
      busy_r <= 1'b0;
    end
  end

  // done is one cycle wide; the stop itself is issued by the sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      homing_done_r <= 1'b0;
    end else begin
      homing_done_r <= home_hit;
    end
  end

  // modes 0 and 10 and up get a refusal for as long as the command is held in idle and never move the axis
  always_ff @(posedge clk) begin
    if (!nrst) begin
      command_refused_r <= 1'b0;
    end else begin
      command_refused_r <= idle_cmd && !mode_ok(mode);
    end
  end

endmodule : axis_homing_sequencer

// [rtl/homing_pkg.sv]
// package: types and constants for the axis homing sequencer
package homing_pkg;

  // width of the homing mode selector
  localparam int unsigned MODE_W = 5;

  // supported homing modes
  localparam logic [MODE_W-1:0] MODE_NEG_LIMIT   = 5'h01;
  localparam logic [MODE_W-1:0] MODE_POS_LIMIT   = 5'h02;
  localparam logic [MODE_W-1:0] MODE_HOME_REV    = 5'h03;
  localparam logic [MODE_W-1:0] MODE_HOME_FWD    = 5'h04;
  localparam logic [MODE_W-1:0] MODE_HOME_NREV   = 5'h05;
  localparam logic [MODE_W-1:0] MODE_HOME_NFWD   = 5'h06;
  localparam logic [MODE_W-1:0] MODE_HOME_PL_REV = 5'h07;
  localparam logic [MODE_W-1:0] MODE_HOME_PL_FWD = 5'h08;
  localparam logic [MODE_W-1:0] MODE_HOME_PL_PAS = 5'h09;

  // switch and index inputs, all active high
  typedef struct packed {
    logic neg_limit;
    logic pos_limit;
    logic home_sw;
    logic index_z;
  } sw_type;

  // command to the downstream motion generator
  typedef struct packed {
    logic move;     // axis in motion
    logic dir_pos;  // 1 = positive direction
    logic phase2;   // 1 = second-phase speed, 0 = first-phase speed
  } motion_type;

  // reset values
  localparam sw_type     SW_RESET     = 4'h0;
  localparam motion_type MOTION_RESET = 3'h0;

  // sequencer states, gray coded along the usual path from idle to index
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEG1  = 3'h1,
    ST_LEG2  = 3'h3,
    ST_LEG3  = 3'h2,
    ST_LEG4  = 3'h6,
    ST_INDEX = 3'h7
  } state_type;

endpackage : homing_pkg

// [dv/axis_plant.sv]
// partner model: axis on a line with limit, home cam and index marks
`timescale 1ns/1ps
module axis_plant (
  input  wire logic                   clk,
  input  wire homing_pkg::motion_type motion_r,
  output homing_pkg::sw_type          sw_pins
);
  int         pos = 0;        // steps, placed by the bench while idle
  int         idx_pos = 0;    // where the last index mark was seen
  logic       half_r = 1'b0;  // halves the step rate at second phase
  logic [2:0] legs_q[$];      // each change of moving command, in order

  ////////////////////////////////////////////////////////////////////
  // geometry: limits at -100 and 200, cam 40..72, marks every 16 steps
  assign sw_pins.neg_limit = (pos <= -100);
  assign sw_pins.pos_limit = (pos >= 200);
  assign sw_pins.home_sw   = (pos >= 40 && pos <= 72);
  assign sw_pins.index_z   = (pos % 16 == 0);

  // slow phase steps every other cycle, so a mark stays up two cycles
  always @(posedge clk) begin
    half_r <= !half_r;
    if (motion_r.move && (!motion_r.phase2 || half_r)) begin
      pos <= motion_r.dir_pos ? pos + 1 : pos - 1;
    end
    if (sw_pins.index_z) begin
      idx_pos <= pos;
    end
    if (motion_r.move && (legs_q.size() == 0 || legs_q[$] != motion_r)) begin
      legs_q.push_back(motion_r);
    end
  end
endmodule : axis_plant

// [dv/axis_homing_sequencer_chk.sv]
// checker: port relations of the homing sequencer
`timescale 1ns/1ps
module axis_homing_sequencer_chk (
  input wire logic                          clk,
  input wire logic                          nrst,
  input wire logic                          homing_command,
  input wire logic [homing_pkg::MODE_W-1:0] mode,
  input wire homing_pkg::sw_type            sw_pins,
  input wire homing_pkg::motion_type        motion_r,
  input wire logic                          busy_r,
  input wire logic                          homing_done_r,
  input wire logic                          command_refused_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take;
  // a command is taken only while the sequencer is idle
  assign take = homing_command && !busy_r;

  property p_start;
    take && mode inside {[5'h01:5'h09]} |=> busy_r && motion_r.move;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_refuse;
    take && !(mode inside {[5'h01:5'h09]}) |=> command_refused_r && !busy_r && !motion_r.move;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad mode not refused");
  property p_done_pulse;
    homing_done_r |=> !homing_done_r;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_done_stop;
    homing_done_r |-> !motion_r.move && !busy_r && $past(busy_r);
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("axis not stopped");
  property p_idle_still;
    !busy_r |-> !motion_r.move;
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("idle motion");
  property p_busy_end;
    $fell(busy_r) |-> homing_done_r;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ends silently");
  property p_done_index;
    homing_done_r |-> $past(sw_pins.index_z, 3) && !$past(sw_pins.index_z, 4);
  endproperty
  a_done_index: assert property (p_done_index) else $error("done off index");
  property p_m1_dir;
    take && mode == 5'h01 && $past(nrst, 3) && $stable(sw_pins.neg_limit)
      && $past(sw_pins.neg_limit, 2) == sw_pins.neg_limit
      |=> motion_r == {1'b1, {2{$past(sw_pins.neg_limit)}}};
  endproperty
  a_m1_dir: assert property (p_m1_dir) else $error("mode 1 start wrong");
  property p_m3_dir;
    take && mode == 5'h03 && $past(nrst, 3) && $stable(sw_pins.home_sw)
      && $past(sw_pins.home_sw, 2) == sw_pins.home_sw
      |=> motion_r == {1'b1, !$past(sw_pins.home_sw), $past(sw_pins.home_sw)};
  endproperty
  a_m3_dir: assert property (p_m3_dir) else $error("mode 3 start wrong");
  c_done: cover property (homing_done_r);
  c_refused: cover property (command_refused_r);
  c_reverse: cover property (busy_r && motion_r.move && $changed(motion_r.dir_pos));
endmodule : axis_homing_sequencer_chk

bind axis_homing_sequencer axis_homing_sequencer_chk u_chk (.clk(clk), .nrst(nrst),
  .homing_command(homing_command), .mode(mode), .sw_pins(sw_pins), .motion_r(motion_r),
  .busy_r(busy_r), .homing_done_r(homing_done_r), .command_refused_r(command_refused_r));

// [dv/axis_homing_sequencer_test.sv]
// testbench: every homing case run over the model axis
`timescale 1ns/1ps
module axis_homing_sequencer_test;
  logic                          clk;
  logic                          nrst;
  logic                          homing_command;
  logic [homing_pkg::MODE_W-1:0] mode;
  homing_pkg::sw_type            sw_pins;
  homing_pkg::motion_type        motion_r;
  logic                          busy_r;
  logic                          homing_done_r;
  logic                          command_refused_r;
  logic [31:0]                   lfsr_r;
  int                            error_cnt;
  int                            checks_done;
  logic                          timed_out;

  axis_homing_sequencer u_dut (.clk(clk), .nrst(nrst), .homing_command(homing_command),
    .mode(mode), .sw_pins(sw_pins), .motion_r(motion_r), .busy_r(busy_r),
    .homing_done_r(homing_done_r), .command_refused_r(command_refused_r));
  axis_plant u_plant (.clk(clk), .motion_r(motion_r), .sw_pins(sw_pins));

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // legs: expected moving commands as hex digits {move,dir_pos,phase2}, first leftmost;
  // busy noise on mode and command must be ignored
  task automatic run(input logic [4:0] m, input int start, input logic [15:0] legs,
                     input int home);
    logic [15:0] got;
    int          n;
    got = 16'h0000;
    n = 0;
    if (timed_out) begin
      return;                        // a hung run already counted its error; the remaining runs are skipped
    end
    u_plant.pos = start;
    u_plant.legs_q.delete();
    repeat (4) @(posedge clk);
    homing_command <= 1'b1;
    mode <= m;
    do begin
      @(posedge clk);
      lfsr_r = lfsr_next(lfsr_r);
      homing_command <= (n < 8) ? lfsr_r[5] : 1'b0;
      mode <= lfsr_r[4:0];
      n++;
      #1;
    end while (homing_done_r !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;                   // home never found counts as a mismatch
      timed_out = 1'b1;
      return;
    end
    foreach (u_plant.legs_q[i]) got = {got[11:0], 1'b0, u_plant.legs_q[i]};
    check(got, legs);
    check(u_plant.idx_pos, home);
    check(motion_r, 3'h0);
    check(busy_r, 1'b0);
  endtask : run

  ////////////////////////////////////////////////////////////////////
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    logic [4:0] bad[3];
    bad = '{5'h00, 5'h0A, 5'h1F};
    nrst = 1'b0;
    homing_command = 1'b0;
    mode = 5'h00;
    lfsr_r = 32'hE4FDF648;
    error_cnt = 0;
    checks_done = 0;
    timed_out = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    run(5'h01, 0, 16'h0047, -96);
    run(5'h01, -120, 16'h0007, -96);
    run(5'h02, 0, 16'h0065, 192);
    run(5'h02, 210, 16'h0005, 192);
    run(5'h03, 0, 16'h0065, 32);
    run(5'h03, 50, 16'h0005, 32);
    run(5'h04, 0, 16'h0067, 48);
    run(5'h04, 50, 16'h0057, 48);
    run(5'h05, 50, 16'h0007, 80);
    run(5'h05, 100, 16'h0047, 80);
    run(5'h06, 50, 16'h0075, 64);
    run(5'h06, 100, 16'h0045, 64);
    run(5'h07, 0, 16'h0065, 32);
    run(5'h07, 50, 16'h0005, 32);
    run(5'h07, 100, 16'h0645, 32);
    run(5'h08, 0, 16'h0067, 48);
    run(5'h08, 50, 16'h0057, 48);
    run(5'h08, 100, 16'h6467, 48);
    run(5'h09, 0, 16'h0675, 64);
    run(5'h09, 50, 16'h0075, 64);
    run(5'h09, 100, 16'h0645, 64);
    // unsupported modes answer with a refusal and never move
    foreach (bad[i]) begin
      @(posedge clk);
      homing_command <= 1'b1;
      mode <= bad[i];
      @(posedge clk);
      homing_command <= 1'b0;
      #1;
      check({command_refused_r, busy_r, motion_r}, 5'h10);
    end
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule : axis_homing_sequencer_test
